// [hw/i2cgx_defines.vh]
// Constants of the I2C port expander register bank
`ifndef I2CGX_DEFINES_VH
`define I2CGX_DEFINES_VH
`define I2CGX_CMD_LEVEL 8'h00
`define I2CGX_CMD_LATCH 8'h01
`define I2CGX_CMD_INVERT 8'h02
`define I2CGX_CMD_DIR 8'h03
`define I2CGX_RST_LATCH 8'h00
`define I2CGX_RST_INVERT 8'hF0
`define I2CGX_RST_DIR 8'hFF
`define I2CGX_RST_CMD 8'h00
`define I2CGX_ADDR_FIXED 4'h3
`define I2CGX_BIT_LAST 3'h7
`define I2CGX_ZERO_BYTE 8'h00
`define I2CGX_SYNC_IDLE_CTL 6'h3F
`define I2CGX_SYNC_IDLE_PIN 8'hFF
`endif

// [hw/i2cgx_sync.v]
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module i2cgx_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage_one;
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      stage_one <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end
endmodule

// [hw/i2cgx_edge.v]
// Edge finder for synchronised SCL and SDA; combinational outputs against registered previous samples
`timescale 1ns/1ps
module i2cgx_edge (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output wire scl_rise_o,
  output wire scl_fall_o,
  output wire start_o,
  output wire stop_o
);
  reg scl_prev;
  reg sda_prev;
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= scl_i;
      sda_prev <= sda_i;
    end
  end
  assign scl_rise_o = scl_i & ~scl_prev;
  assign scl_fall_o = ~scl_i & scl_prev;
  // Data edges only count while SCL stays high across both samples
  assign start_o = scl_i & scl_prev & sda_prev & ~sda_i;
  assign stop_o = scl_i & scl_prev & ~sda_prev & sda_i;
endmodule

// [hw/i2cgx_top.v]
// I2C port expander: serial slave, register bank and pin control
// Contract
// - First byte after address is command; 0 input, 1-3 latch, invert, direction.
// - Data written while pointer selects input register is discarded.
// - Input register shows live pin levels regardless of direction.
// - Output pins drive latch bits; input pins ignore latch.
// - Latch read returns stored value, not sensed pin levels.
// - Invert bit one flips the pin level in the input register.
// - Invert resets to F0, latch resets to zero.
// - Direction one is input, zero output; resets all ones.
// - Command pointer persists across reads until a new command.
// - Power-on reset initialises registers and serial state machine.
// - STOP keeps acknowledged bytes, discards a partial byte.
// - Address byte is 0011, three address pins, then read bit.
// - Acknowledge matching address and every written byte.
// - Read continues while master acknowledges; no ack waits for STOP.
// - Reset pin low holds registers and state machine in defaults.
`timescale 1ns/1ps
`include "i2cgx_defines.vh"
module i2cgx_top (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire reset_pin_n_i,
  input wire addr_pin_low_i,
  input wire addr_pin_mid_i,
  input wire addr_pin_high_i,
  input wire [7:0] pin_i,
  output reg [7:0] pin_o,
  output reg [7:0] pin_oe_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_WAIT_STOP = 3'h5;
  localparam ST_START = 3'h6;

  wire [5:0] ctl_in;
  wire [5:0] ctl_out;
  wire scl_s;
  wire sda_s;
  wire reset_pin_n_s;
  wire [7:0] pin_s;
  wire [2:0] addr_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire rst_all_n;

  reg [7:0] output_latch;
  reg [7:0] read_invert_mask;
  reg [7:0] direction_select;
  reg [7:0] cmd_ptr;
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shift;
  reg ack_phase;
  reg ack_drive;
  reg rd_ack_seen;
  reg [7:0] rd_byte;
  reg [7:0] pin_level_sample;
  reg [7:0] next_rd_byte;

  // Bus lines, reset pin and straps all idle high, so their stages start high
  assign ctl_in = {scl_i, sda_i, reset_pin_n_i, addr_pin_high_i, addr_pin_mid_i,
                   addr_pin_low_i};
  i2cgx_sync #(
    .WIDTH(6),
    .INIT(`I2CGX_SYNC_IDLE_CTL)
  ) u_sync_ctl (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ctl_in),
    .sync_o(ctl_out)
  );
  // Port levels only feed the input register, so they get a two-stage synchroniser of their own
  i2cgx_sync #(
    .WIDTH(8),
    .INIT(`I2CGX_SYNC_IDLE_PIN)
  ) u_sync_pin (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_i),
    .sync_o(pin_s)
  );
  assign scl_s = ctl_out[5];
  assign sda_s = ctl_out[4];
  assign reset_pin_n_s = ctl_out[3];
  assign addr_s = ctl_out[2:0];

  i2cgx_edge u_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_cond),
    .stop_o(stop_cond)
  );

  // Either the core reset or the reset pin holds this module's registers at defaults; the synchronisers and edge finder see only the core reset
  assign rst_all_n = rst_n_i & reset_pin_n_s;

  // Input register view: live pin levels with per-bit inversion
  always @*
  begin
    pin_level_sample = pin_s ^ read_invert_mask;
  end

  always @*
  begin
    if (cmd_ptr == `I2CGX_CMD_LEVEL)
      next_rd_byte = pin_level_sample;
    else if (cmd_ptr == `I2CGX_CMD_LATCH)
      next_rd_byte = output_latch;
    else if (cmd_ptr == `I2CGX_CMD_INVERT)
      next_rd_byte = read_invert_mask;
    else if (cmd_ptr == `I2CGX_CMD_DIR)
      next_rd_byte = direction_select;
    else
      next_rd_byte = `I2CGX_ZERO_BYTE;
  end

  // Serial slave: bits sampled on SCL rise, SDA changed on SCL fall
  always @(posedge core_clk_i)
  begin
    if (!rst_all_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= `I2CGX_ZERO_BYTE;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
      rd_ack_seen <= 1'b0;
      rd_byte <= `I2CGX_ZERO_BYTE;
      cmd_ptr <= `I2CGX_RST_CMD;
      output_latch <= `I2CGX_RST_LATCH;
      read_invert_mask <= `I2CGX_RST_INVERT;
      direction_select <= `I2CGX_RST_DIR;
    end
    else if (start_cond)
    begin
      state <= ST_START;
      bit_cnt <= 3'h0;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
    end
    else if (stop_cond)
    begin
      // A partial byte is simply dropped; only acked bytes ever wrote
      state <= ST_IDLE;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_phase)
      begin
        if (state == ST_RDATA)
          rd_ack_seen <= ~sda_s;
      end
      else if (state != ST_IDLE && state != ST_WAIT_STOP && state != ST_START)
      begin
        shift <= {shift[6:0], sda_s};
      end
    end
    else if (scl_fall)
    begin
      case (state)
        ST_START:
        begin
          // The fall that closes a START is not a data bit
          state <= ST_ADDR;
          bit_cnt <= 3'h0;
        end
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (ack_phase)
          begin
            ack_phase <= 1'b0;
            ack_drive <= 1'b0;
            bit_cnt <= 3'h0;
            if (state == ST_ADDR)
            begin
              if (shift[0])
              begin
                state <= ST_RDATA;
                rd_byte <= next_rd_byte;
              end
              else
                state <= ST_CMD;
            end
            else
              state <= ST_WDATA;
          end
          else if (bit_cnt == `I2CGX_BIT_LAST)
          begin
            bit_cnt <= 3'h0;
            ack_phase <= 1'b1;
            if (state == ST_ADDR)
            begin
              if (shift[7:4] == `I2CGX_ADDR_FIXED && shift[3:1] == addr_s)
                ack_drive <= 1'b1;
              else
                state <= ST_WAIT_STOP;
            end
            else if (state == ST_CMD)
            begin
              cmd_ptr <= shift;
              ack_drive <= 1'b1;
            end
            else
            begin
              ack_drive <= 1'b1;
              // Data commits at the ack phase so a later STOP keeps it
              if (cmd_ptr == `I2CGX_CMD_LATCH)
                output_latch <= shift;
              else if (cmd_ptr == `I2CGX_CMD_INVERT)
                read_invert_mask <= shift;
              else if (cmd_ptr == `I2CGX_CMD_DIR)
                direction_select <= shift;
              else
              begin
                // Input register and undefined codes leave every register alone
                output_latch <= output_latch;
              end
            end
          end
          else
            bit_cnt <= bit_cnt + 3'h1;
        end
        ST_RDATA:
        begin
          if (ack_phase)
          begin
            ack_phase <= 1'b0;
            bit_cnt <= 3'h0;
            if (rd_ack_seen)
              rd_byte <= next_rd_byte;
            else
              state <= ST_WAIT_STOP;
          end
          else if (bit_cnt == `I2CGX_BIT_LAST)
          begin
            ack_phase <= 1'b1;
            rd_ack_seen <= 1'b0;
          end
          else
          begin
            bit_cnt <= bit_cnt + 3'h1;
            rd_byte <= {rd_byte[6:0], 1'b0};
          end
        end
        default:
        begin
          state <= state;
        end
      endcase
    end
  end

  // Open-drain SDA: pull low for ack or a zero data bit
  always @(posedge core_clk_i)
  begin
    if (!rst_all_n)
    begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      if (state == ST_RDATA && !ack_phase)
        sda_oe_o <= ~rd_byte[7];
      else
        sda_oe_o <= ack_drive & ack_phase;
    end
  end

  // Pin drivers follow direction and latch one cycle later
  always @(posedge core_clk_i)
  begin
    if (!rst_all_n)
    begin
      pin_o <= `I2CGX_RST_LATCH;
      pin_oe_o <= `I2CGX_ZERO_BYTE;
    end
    else
    begin
      pin_o <= output_latch;
      pin_oe_o <= ~direction_select;
    end
  end
endmodule

// [verification/i2cgx_chk.sv]
// Checker for the port expander pins and serial data line
`timescale 1ns/1ps
module i2cgx_chk (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire reset_pin_n_i,
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_bit_held;
    sda_oe_o [*4];
  endsequence
  sequence s_pin_reset;
    !reset_pin_n_i [*6];
  endsequence
  a_ack_stands: assert property ($rose(sda_oe_o) |-> s_bit_held)
    else $error("serial drive dropped too early");
  a_sda_low_edge: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("serial drive changed outside clock low");
  a_sda_steady: assert property (scl_i [*3] |-> $stable(sda_oe_o))
    else $error("serial drive changed while clock high");
  a_open_drain: assert property (sda_oe_o |-> !sda_o)
    else $error("serial line driven high");
  a_latch_timing: assert property ($changed(pin_o) && reset_pin_n_i &&
    $past(reset_pin_n_i, 6) |-> !$past(scl_i, 2)) else $error("pin level moved off a write");
  a_dir_timing: assert property ($changed(pin_oe_o) && reset_pin_n_i &&
    $past(reset_pin_n_i, 6) |-> !$past(scl_i, 2)) else $error("pin drive moved off a write");
  a_pin_reset_hold: assert property (s_pin_reset |-> pin_oe_o == 8'h00 &&
    pin_o == 8'h00 && !sda_oe_o) else $error("reset pin did not clear outputs");
  a_after_reset: assert property ($rose(rst_n_i) |-> pin_oe_o == 8'h00 && !sda_oe_o)
    else $error("outputs not idle after reset");
endmodule
bind i2cgx_top i2cgx_chk u_chk (.core_clk_i, .rst_n_i, .scl_i, .sda_o, .sda_oe_o,
  .reset_pin_n_i, .pin_o, .pin_oe_o);

// [verification/i2cgx_master.sv]
// Behavioural bus master: open-drain data, clock idles high between frames
`timescale 1ns/1ps
module i2cgx_master (
  input wire core_clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Data moves only mid-low so it never looks like a START or STOP
  task bit_io(input b, output r);
  begin
    sda_low_o <= ~b;
    // A longer low phase lets the slave's reply settle before SCL rises
    wt(3);
    scl_o <= 1'b1;
    wt(3);
    r = sda_i;
    scl_o <= 1'b0;
    wt(2);
  end
  endtask
  task start;
  begin
    sda_low_o <= 1'b0;
    wt(4);
    sda_low_o <= 1'b1;
    wt(4);
    scl_o <= 1'b0;
    wt(2);
  end
  endtask
  task stop;
  begin
    sda_low_o <= 1'b1;
    wt(2);
    scl_o <= 1'b1;
    wt(4);
    sda_low_o <= 1'b0;
    wt(4);
  end
  endtask
  task xfer(input [7:0] d, input ack_in, output [7:0] q, output ack);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  end
  endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the port expander register bank
`timescale 1ns/1ps
`include "i2cgx_defines.vh"
module tb;
  reg core_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg reset_pin_n_i = 1'b1;
  reg [2:0] strap = 3'h5;
  reg [7:0] pin_i = 8'h5A;
  wire scl, sda_low, sda_o, sda_oe_o;
  wire [7:0] pin_o, pin_oe_o;
  // Pull-up wins when nobody pulls the data wire
  wire sda = ~(sda_low | (sda_oe_o & ~sda_o));
  integer bad_count = 0;
  integer checked = 0;
  reg [7:0] q;
  reg ak;
  always #5 core_clk_i = ~core_clk_i;
  i2cgx_master u_mst (.core_clk_i, .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  i2cgx_top dut (.core_clk_i, .rst_n_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
    .reset_pin_n_i, .addr_pin_low_i(strap[0]), .addr_pin_mid_i(strap[1]),
    .addr_pin_high_i(strap[2]), .pin_i, .pin_o, .pin_oe_o);
  task chk(input string nm, input [7:0] e, input [7:0] g);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wr(input [7:0] c, input [7:0] d, input nd);
  begin
    u_mst.start;
    u_mst.xfer({`I2CGX_ADDR_FIXED, strap, 1'b0}, 1'b1, q, ak);
    chk("address ack", 8'h00, {7'h00, ak});
    u_mst.xfer(c, 1'b1, q, ak);
    if (nd)
      u_mst.xfer(d, 1'b1, q, ak);
    chk("byte ack", 8'h00, {7'h00, ak});
    u_mst.stop;
  end
  endtask
  task rd(input [7:0] e, input string nm);
  begin
    u_mst.start;
    u_mst.xfer({`I2CGX_ADDR_FIXED, strap, 1'b1}, 1'b1, q, ak);
    u_mst.xfer(8'hFF, 1'b1, q, ak);
    u_mst.stop;
    chk(nm, e, q);
  end
  endtask
  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    bad_count = bad_count + 1;
    complete_run;
  end
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    wr(`I2CGX_CMD_LATCH, 8'h00, 1'b0);
    rd(`I2CGX_RST_LATCH, "latch reset");
    wr(`I2CGX_CMD_INVERT, 8'h00, 1'b0);
    rd(`I2CGX_RST_INVERT, "invert reset");
    wr(`I2CGX_CMD_DIR, 8'h00, 1'b0);
    rd(`I2CGX_RST_DIR, "direction reset");
    rd(`I2CGX_RST_DIR, "kept pointer");
    $display("test reset values done");
    wr(`I2CGX_CMD_LEVEL, 8'h00, 1'b0);
    rd(8'h5A ^ `I2CGX_RST_INVERT, "inverted level");
    wr(`I2CGX_CMD_LEVEL, 8'h33, 1'b1);
    wr(`I2CGX_CMD_INVERT, 8'h00, 1'b0);
    rd(`I2CGX_RST_INVERT, "invert kept");
    wr(`I2CGX_CMD_INVERT, 8'h00, 1'b1);
    pin_i <= 8'hC3;
    wr(`I2CGX_CMD_LEVEL, 8'h00, 1'b0);
    rd(8'hC3, "plain level");
    $display("test input levels done");
    wr(`I2CGX_CMD_LATCH, 8'hA5, 1'b1);
    wr(`I2CGX_CMD_DIR, 8'h0F, 1'b1);
    chk("pin drive", 8'hF0, pin_oe_o);
    chk("driven bits", 8'hA0, pin_o & pin_oe_o);
    wr(`I2CGX_CMD_LEVEL, 8'h00, 1'b0);
    rd(8'hC3, "level of driven pins");
    wr(8'h04, 8'h77, 1'b1);
    rd(8'h00, "undefined code");
    u_mst.start;
    u_mst.xfer({`I2CGX_ADDR_FIXED, ~strap, 1'b0}, 1'b1, q, ak);
    u_mst.stop;
    chk("foreign ack", 8'h01, {7'h00, ak});
    u_mst.start;
    u_mst.xfer({`I2CGX_ADDR_FIXED, strap, 1'b0}, 1'b1, q, ak);
    u_mst.xfer(`I2CGX_CMD_LATCH, 1'b1, q, ak);
    repeat (4) u_mst.bit_io(1'b0, ak);
    u_mst.stop;
    rd(8'hA5, "latch readback");
    $display("test outputs done");
    reset_pin_n_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk("held drive", 8'h00, pin_oe_o);
    chk("held level", 8'h00, pin_o);
    reset_pin_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rd(8'hC3 ^ `I2CGX_RST_INVERT, "after reset pin");
    $display("test reset pin done");
    complete_run;
  end
endmodule
